// ===== dsmp_pkg.sv
// constants and carrier types for the drive status and mapping parameter bank
// assumes a word-addressed parameter port driven by the fieldbus front end
`default_nettype none

package dsmp_pkg;

   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 32;
   localparam int          MAP_COUNT       = 4;

   // parameter addresses as the fieldbus sees them
   localparam logic [15:0] ADDR_MAP_PTR_5  = 16'h014E;
   localparam logic [15:0] ADDR_MAP_PTR_6  = 16'h0150;
   localparam logic [15:0] ADDR_MAP_PTR_7  = 16'h0152;
   localparam logic [15:0] ADDR_MAP_PTR_8  = 16'h0154;
   localparam logic [15:0] ADDR_OUT_STATE  = 16'h015C;
   localparam logic [15:0] ADDR_LAST_ALERT = 16'h015E;

   // reset / factory values
   localparam logic [31:0] RST_MAP_PTR     = 32'h0000_0000;
   localparam logic [15:0] RST_OUT_STATE   = 16'h0000;
   localparam logic [15:0] RST_LAST_ALERT  = 16'h0000;

   // output function state bit positions
   localparam int          BIT_READY       = 0;
   localparam int          BIT_PWR_ON      = 1;
   localparam int          BIT_STANDSTILL  = 2;
   localparam int          BIT_VEL_REACHED = 3;
   localparam int          BIT_MOTION_DONE = 4;
   localparam int          BIT_TORQUE_CAP  = 5;
   localparam int          BIT_ERROR       = 6;
   localparam int          BIT_BRAKE       = 7;
   localparam int          BIT_REF_DONE    = 8;
   localparam int          BIT_OVERLOAD    = 9;
   localparam int          BIT_WARNING     = 10;

   // mapping pointer field layout: each half = group code (high byte), number (low byte)
   localparam int          PTR_HI_LSB      = 16;
   localparam int          PTR_GROUP_LSB   = 8;

   typedef struct packed {
      logic driveReadyFlag;
      logic powerStageActive;
      logic standstillFlag;
      logic targetVelocityReached;
      logic motionDoneFlag;
      logic torqueCappedFlag;
      logic errorDetected;
      logic brakeReleaseCtl;
      logic referenceRunDone;
      logic motorOverloadAlert;
      logic limitSwitchTrip;
      logic underVoltage;
      logic nodeGuardAlert;
      logic operationalHalt;
   } dsmp_func_s;

   typedef struct packed {
      logic [7:0] group;
      logic [7:0] number;
   } dsmp_target_s;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dsmp_req_s;

   typedef logic [1:0] dsmp_idx_t;

endpackage : dsmp_pkg

`default_nettype wire

// ===== dsmp_param_bank.sv
// parameter bank: four mapping pointers, output function state, last alert number
// assumes requests, function flags and alert events are synchronous to mclk;
// nonvolatile storage of the pointers lives outside and restores them after reset
`timescale 1ns/10ps
`default_nettype none

module dsmp_param_bank
   import dsmp_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire dsmp_req_s                 req,
   output logic                           rdValid,
   output logic                           rdError,
   output logic                           wrError,
   output logic       [DATA_W-1:0]        rdData,
   input  wire logic                      restoreValid,
   input  wire dsmp_idx_t                 restoreIndex,
   input  wire logic  [DATA_W-1:0]        restoreData,
   input  wire dsmp_func_s                funcState,
   input  wire logic                      alertValid,
   input  wire logic  [15:0]              alertNumber,
   input  wire logic                      faultReset,
   output logic       [MAP_COUNT*DATA_W-1:0] mapPointers,
   output dsmp_target_s [2*MAP_COUNT-1:0] mapTargets
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode, shared by reads and writes

   function automatic logic [3:0] mapHit(input logic [ADDR_W-1:0] a);
      mapHit = {a == ADDR_MAP_PTR_8, a == ADDR_MAP_PTR_7,
                a == ADDR_MAP_PTR_6, a == ADDR_MAP_PTR_5};
   endfunction : mapHit

   function automatic dsmp_target_s halfTarget(input logic [15:0] h);
      halfTarget.group  = h[15:PTR_GROUP_LSB];
      halfTarget.number = h[PTR_GROUP_LSB-1:0];
   endfunction : halfTarget

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic rstMeta;
   logic rstSync;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   wire logic rstInt_n = rstSync;

   ////////////////////////////////////////////////////////////////////////////
   // mapping pointers

   logic [DATA_W-1:0] mapPtr [MAP_COUNT];
   logic [3:0]        wrHit;

   assign wrHit = req.wr ? mapHit(req.addr) : 4'h0;

   always_ff @(posedge mclk or negedge rstInt_n)
   begin
      if (!rstInt_n)
      begin
         for (int i = 0; i < MAP_COUNT; i++)
            mapPtr[i] <= RST_MAP_PTR;
      end
      else
      begin
         for (int i = 0; i < MAP_COUNT; i++)
         begin
            // a fieldbus write overrides a restore landing in the same cycle
            if (wrHit[i])
               mapPtr[i] <= req.wdata;
            else if (restoreValid && restoreIndex == dsmp_idx_t'(i))
               mapPtr[i] <= restoreData;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstInt_n)
   begin
      if (!rstInt_n)
      begin
         mapPointers <= '0;
         mapTargets  <= '0;
      end
      else
      begin
         for (int i = 0; i < MAP_COUNT; i++)
         begin
            mapPointers[i*DATA_W +: DATA_W] <= mapPtr[i];
            // low half names the 32-bit or first 16-bit target
            mapTargets[2*i]   <= halfTarget(mapPtr[i][PTR_HI_LSB-1:0]);
            mapTargets[2*i+1] <= halfTarget(mapPtr[i][DATA_W-1:PTR_HI_LSB]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output function state, sampled every cycle from the unforced function levels

   logic [15:0] outState;
   logic [15:0] next_outState;

   always_comb
   begin
      next_outState                  = RST_OUT_STATE;
      next_outState[BIT_READY]       = funcState.driveReadyFlag;
      next_outState[BIT_PWR_ON]      = funcState.powerStageActive;
      next_outState[BIT_STANDSTILL]  = funcState.standstillFlag;
      next_outState[BIT_VEL_REACHED] = funcState.targetVelocityReached;
      next_outState[BIT_MOTION_DONE] = funcState.motionDoneFlag;
      next_outState[BIT_TORQUE_CAP]  = funcState.torqueCappedFlag;
      next_outState[BIT_ERROR]       = funcState.errorDetected;
      next_outState[BIT_BRAKE]       = funcState.brakeReleaseCtl;
      next_outState[BIT_REF_DONE]    = funcState.referenceRunDone;
      next_outState[BIT_OVERLOAD]    = funcState.motorOverloadAlert;
      next_outState[BIT_WARNING]     = funcState.limitSwitchTrip
                                     | funcState.underVoltage
                                     | funcState.nodeGuardAlert
                                     | funcState.operationalHalt;
   end

   always_ff @(posedge mclk or negedge rstInt_n)
   begin
      if (!rstInt_n)
         outState <= RST_OUT_STATE;
      else
         outState <= next_outState;
   end

   ////////////////////////////////////////////////////////////////////////////
   // last alert number

   logic [15:0] lastAlert;

   always_ff @(posedge mclk or negedge rstInt_n)
   begin
      if (!rstInt_n)
         lastAlert <= RST_LAST_ALERT;
      else if (alertValid)
         lastAlert <= alertNumber;
      else if (faultReset)
         lastAlert <= RST_LAST_ALERT;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port and access errors

   logic [3:0] rdHit;
   logic       rdOk;

   assign rdHit = mapHit(req.addr);
   assign rdOk  = (|rdHit) || req.addr == ADDR_OUT_STATE || req.addr == ADDR_LAST_ALERT;

   always_ff @(posedge mclk or negedge rstInt_n)
   begin
      if (!rstInt_n)
      begin
         rdValid <= 1'b0;
         rdError <= 1'b0;
         wrError <= 1'b0;
         rdData  <= '0;
      end
      else
      begin
         rdValid <= req.rd;
         rdError <= req.rd && !rdOk;
         // read-only or unmapped write is dropped and flagged
         wrError <= req.wr && !(|wrHit);
         rdData  <= '0;
         if (req.rd)
         begin
            for (int i = 0; i < MAP_COUNT; i++)
               if (rdHit[i])
                  rdData <= mapPtr[i];
            if (req.addr == ADDR_OUT_STATE)
               rdData <= {16'h0000, outState};
            if (req.addr == ADDR_LAST_ALERT)
               rdData <= {16'h0000, lastAlert};
         end
      end
   end

endmodule : dsmp_param_bank

`default_nettype wire

// ===== dsmp_param_bank_props.sv
// port checker for the parameter bank
// assumes it is bound onto dsmp_param_bank
`timescale 1ns/10ps
`default_nettype none
module dsmp_param_bank_props
   import dsmp_pkg::*;
(
   input wire logic               mclk,
   input wire logic               rst_n,
   input wire dsmp_req_s          req,
   input wire logic               rdValid,
   input wire logic               rdError,
   input wire logic               wrError,
   input wire logic [31:0]        rdData,
   input wire logic               restoreValid,
   input wire dsmp_func_s         funcState,
   input wire logic               alertValid,
   input wire logic [15:0]        alertNumber,
   input wire logic               faultReset,
   input wire logic [127:0]       mapPointers,
   input wire dsmp_target_s [7:0] mapTargets
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   function automatic logic [15:0] word(input dsmp_func_s f);
      word = {5'h00, |f[3:0], f[4], f[5], f[6], f[7], f[8], f[9], f[10], f[11], f[12], f[13]};
   endfunction : word
   sequence rdAlert_s;
      req.rd && req.addr == ADDR_LAST_ALERT && !alertValid;
   endsequence
   sequence calm_s;
      !alertValid && !faultReset;
   endsequence
   rd_valid_a: assert property (req.rd |=> rdValid) else $error("no rdValid");
   no_valid_a: assert property (!req.rd |=> !rdValid) else $error("stray rdValid");
   ptr_store_a: assert property (req.wr && req.addr == ADDR_MAP_PTR_5
      ##1 !req.wr && !restoreValid |=> mapPointers[31:0] == $past(req.wdata, 2))
      else $error("ptr store");
   ptr_fields_a: assert property (mapTargets == mapPointers) else $error("targets");
   status_word_a: assert property (req.rd && req.addr == ADDR_OUT_STATE
      |=> rdData == {16'h0000, word($past(funcState, 2))}) else $error("status");
   ro_write_a: assert property (req.wr && (req.addr == ADDR_OUT_STATE
      || req.addr == ADDR_LAST_ALERT) |=> wrError) else $error("ro write");
   alert_keep_a: assert property (alertValid && !faultReset ##1 calm_s ##1 rdAlert_s
      |=> rdData == {16'h0000, $past(alertNumber, 3)}) else $error("alert");
   alert_wins_a: assert property (alertValid && faultReset ##1 calm_s ##1 rdAlert_s
      |=> rdData == {16'h0000, $past(alertNumber, 3)}) else $error("set over clear");
   alert_clear_a: assert property (faultReset && !alertValid ##1 calm_s ##1 rdAlert_s
      |=> rdData == 32'h0000_0000) else $error("clear");
   bad_read_a: assert property (req.rd && req.addr == 16'h014F
      |=> rdError && rdData == 32'h0000_0000) else $error("unmapped");
endmodule : dsmp_param_bank_props
bind dsmp_param_bank dsmp_param_bank_props i_props (.mclk(mclk), .rst_n(rst_n), .req(req),
   .rdValid(rdValid), .rdError(rdError), .wrError(wrError), .rdData(rdData),
   .restoreValid(restoreValid), .funcState(funcState), .alertValid(alertValid),
   .alertNumber(alertNumber), .faultReset(faultReset), .mapPointers(mapPointers),
   .mapTargets(mapTargets));
`default_nettype wire

// ===== dsmp_bus_master.sv
// fieldbus master model issuing one-word parameter requests
// assumes the bank samples req on rising mclk
`timescale 1ns/10ps
`default_nettype none
module dsmp_bus_master
   import dsmp_pkg::*;
(
   input  wire logic      mclk,
   output var  dsmp_req_s req
);
   initial req = '0;
   // idle bus shows inverted lines so a stale address never passes for valid
   task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk) req <= '{w, !w, a, d};
      @(posedge mclk) req <= '{1'b0, 1'b0, ~a, ~d};
      #1;
   endtask : access
endmodule : dsmp_bus_master
`default_nettype wire

// ===== drive_status_and_map_params_tb_top.sv
// self-checking bench for the parameter bank
// assumes the checker binds itself and the master model drives req
`timescale 1ns/10ps
`default_nettype none
module drive_status_and_map_params_tb_top
   import dsmp_pkg::*;
;
   logic               mclk, rst_n, restoreValid, alertValid, faultReset;
   logic               rdValid, rdError, wrError;
   logic [31:0]        rdData, restoreData;
   logic [15:0]        alertNumber;
   logic [127:0]       mapPointers;
   dsmp_idx_t          restoreIndex;
   dsmp_func_s         funcState;
   dsmp_req_s          req;
   dsmp_target_s [7:0] mapTargets;
   int                 numErrors, totalChecks, cycles;
   logic [15:0]        adr [6] = '{ADDR_MAP_PTR_5, ADDR_MAP_PTR_6, ADDR_MAP_PTR_7,
                                   ADDR_MAP_PTR_8, ADDR_OUT_STATE, ADDR_LAST_ALERT};
   dsmp_bus_master i_master (.mclk(mclk), .req(req));
   dsmp_param_bank i_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdValid(rdValid),
      .rdError(rdError), .wrError(wrError), .rdData(rdData), .restoreValid(restoreValid),
      .restoreIndex(restoreIndex), .restoreData(restoreData), .funcState(funcState),
      .alertValid(alertValid), .alertNumber(alertNumber), .faultReset(faultReset),
      .mapPointers(mapPointers), .mapTargets(mapTargets));
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
      totalChecks++;
      if (s !== e)
      begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      i_master.access(1'b0, a, 32'h0000_0000);
      check("rdData", e, rdData);
      check("rdValid", 32'h1, {31'h0, rdValid});
   endtask : rd
   task automatic reportAndStop;
      $display("checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : reportAndStop
   // whole run is about 150 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         numErrors++;
         reportAndStop();
      end
   end
   initial
   begin
      {rst_n, restoreValid, alertValid, faultReset, restoreIndex} = '0;
      {restoreData, alertNumber, funcState} = '0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 6; i++) rd(adr[i], 32'h0000_0000);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) i_master.access(1'b1, adr[i], 32'hA5C3_0F00 | i);
      for (int i = 0; i < 4; i++) rd(adr[i], 32'hA5C3_0F00 | i);
      for (int i = 0; i < 4; i++) check("mapPointers", 32'hA5C3_0F00 | i, mapPointers[32*i+:32]);
      for (int i = 0; i < 4; i++)
         check("mapTargets", 32'hA5C3_0F00 | i, {mapTargets[2*i+1], mapTargets[2*i]});
      for (int i = 4; i < 6; i++)
      begin
         i_master.access(1'b1, adr[i], 32'hFFFF_FFFF);
         check("wrError", 32'h1, {31'h0, wrError});
         rd(adr[i], 32'h0000_0000);
      end
      rd(16'h014F, 32'h0000_0000);
      check("rdError", 32'h1, {31'h0, rdError});
      @(posedge mclk) restoreValid <= 1'b1;
      restoreIndex <= 2'h3;
      restoreData <= 32'h0204_0202;
      @(posedge mclk) restoreValid <= 1'b0;
      rd(ADDR_MAP_PTR_8, 32'h0204_0202);
      $display("test pointers done");
      for (int i = 0; i < 14; i++)
      begin
         @(posedge mclk) funcState <= 14'h2000 >> i;
         repeat (2) @(posedge mclk);
         rd(ADDR_OUT_STATE, 32'h1 << (i < 10 ? i : 10));
      end
      $display("test status word done");
      @(posedge mclk) alertNumber <= 16'h0123;
      alertValid <= 1'b1;
      @(posedge mclk) alertValid <= 1'b0;
      rd(ADDR_LAST_ALERT, 32'h0000_0123);
      @(posedge mclk) faultReset <= 1'b1;
      @(posedge mclk) faultReset <= 1'b0;
      rd(ADDR_LAST_ALERT, 32'h0000_0000);
      @(posedge mclk) alertNumber <= 16'h0456;
      alertValid <= 1'b1;
      faultReset <= 1'b1;
      @(posedge mclk) alertValid <= 1'b0;
      faultReset <= 1'b0;
      rd(ADDR_LAST_ALERT, 32'h0000_0456);
      $display("test alert record done");
      @(posedge mclk) rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(ADDR_MAP_PTR_5, 32'h0000_0000);
      rd(ADDR_MAP_PTR_8, 32'h0000_0000);
      $display("test reset in mid-run done");
      reportAndStop();
   end
endmodule : drive_status_and_map_params_tb_top
`default_nettype wire
